// [potc_top.sv]
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module potc_top
  import potc_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [ADDR_W-1:0]                  paddr,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata,
  output wire logic                               pready,
  output logic                                    pslverr,
  input  wire logic [potc_pkg::POTC_CHANNELS-1:0] cm_a,
  input  wire logic [potc_pkg::POTC_CHANNELS-1:0] cm_b,
  output logic      [potc_pkg::POTC_OUT_W-1:0]    pattern_out,
  output logic      [7:0]                         port_a_pin,
  output logic      [7:0]                         port_a_oe,
  output logic      [7:0]                         port_b_pin,
  output logic      [7:0]                         port_b_oe
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  // the highest index needs ten address bits
  if (ADDR_W < 10)
  begin : g_bad_addr
    $error("potc_top: ADDR_W must be at least 10");
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [3:0]               grp_nonoverlap;  // per-group mode bits
  logic [7:0]               trig_sel;        // four 2-bit selects
  logic [7:0]               data_enable_low; // outputs 7..0
  logic [7:0]               data_enable_high;// outputs 15..8
  logic [POTC_OUT_W-1:0]    next_data;       // next pattern
  logic [POTC_OUT_W-1:0]    grp_out;         // gathered group outputs
  wire logic [POTC_OUT_W-1:0] enable_all;    // both enables, output order
  logic [31:0]              next_prdata;     // read mux result
  logic                     next_slverr;     // unmapped access

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire logic [ADDR_W-3:0] word_idx;   // word index of the access
  wire logic              aligned;    // low address bits zero
  wire logic              setup;      // setup phase of a transfer
  wire logic              wr_en;      // write takes effect
  wire logic              hit_mode;
  wire logic              hit_trig;
  wire logic              hit_en_hi;
  wire logic              hit_en_lo;
  wire logic              hit_g3;
  wire logic              hit_g1;
  wire logic              hit_g2;
  wire logic              hit_g0;
  wire logic              hit_stat;
  wire logic              hit_any;
  wire logic              same_23;    // groups 2 and 3 share a trigger
  wire logic              same_01;    // groups 0 and 1 share a trigger

  assign word_idx  = paddr[ADDR_W-1:2];
  assign aligned   = (paddr[1:0] == 2'h0);
  assign setup     = psel && !penable;
  assign wr_en     = psel && penable && pwrite && hit_any;
  assign hit_mode  = aligned && (word_idx == (ADDR_W-2)'(POTC_IDX_MODE));
  assign hit_trig  = aligned && (word_idx == (ADDR_W-2)'(POTC_IDX_TRIG));
  assign hit_en_hi = aligned && (word_idx == (ADDR_W-2)'(POTC_IDX_EN_HI));
  assign hit_en_lo = aligned && (word_idx == (ADDR_W-2)'(POTC_IDX_EN_LO));
  assign hit_g3    = aligned && (word_idx == (ADDR_W-2)'(POTC_IDX_NXT_G3));
  assign hit_g1    = aligned && (word_idx == (ADDR_W-2)'(POTC_IDX_NXT_G1));
  assign hit_g2    = aligned && (word_idx == (ADDR_W-2)'(POTC_IDX_NXT_G2));
  assign hit_g0    = aligned && (word_idx == (ADDR_W-2)'(POTC_IDX_NXT_G0));
  assign hit_stat  = aligned && (word_idx == (ADDR_W-2)'(POTC_IDX_STATUS));
  assign hit_any   = hit_mode | hit_trig | hit_en_hi | hit_en_lo | hit_g3
                   | hit_g1 | hit_g2 | hit_g0 | hit_stat;

  // byte layout of next data follows the trigger pairing
  assign same_23 = (trig_sel[5:4] == trig_sel[7:6]);
  assign same_01 = (trig_sel[1:0] == trig_sel[3:2]);

  // zero wait states: read data is latched in the setup phase
  assign pready = 1'b1;

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    next_slverr = !hit_any;
    if (hit_mode)
      next_prdata[7:0] = {POTC_RSVD_NIB, grp_nonoverlap};
    else if (hit_trig)
      next_prdata[7:0] = trig_sel;
    else if (hit_en_hi)
      next_prdata[7:0] = data_enable_high;
    else if (hit_en_lo)
      next_prdata[7:0] = data_enable_low;
    else if (hit_g3)
      // shared: whole upper byte; split: group 3 only
      next_prdata[7:0] = same_23 ? next_data[15:8]
                                 : {next_data[15:12], POTC_RSVD_NIB};
    else if (hit_g2)
      // shared: nothing lives here
      next_prdata[7:0] = same_23 ? POTC_RSVD_BYTE
                                 : {POTC_RSVD_NIB, next_data[11:8]};
    else if (hit_g1)
      next_prdata[7:0] = same_01 ? next_data[7:0]
                                 : {next_data[7:4], POTC_RSVD_NIB};
    else if (hit_g0)
      next_prdata[7:0] = same_01 ? POTC_RSVD_BYTE
                                 : {POTC_RSVD_NIB, next_data[3:0]};
    else if (hit_stat)
      next_prdata[POTC_OUT_W-1:0] = pattern_out;
    else
      next_prdata = 32'h0000_0000;
  end

  // read data and error captured at setup, stable through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_slverr;
    end
  end

  // ****************************************************************
  // control register writes
  // ****************************************************************
  // reserved bits of the mode register ignore writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      grp_nonoverlap   <= POTC_RST_NONOV;
      trig_sel         <= POTC_RST_TRIG;
      data_enable_low  <= POTC_RST_EN;
      data_enable_high <= POTC_RST_EN;
    end
    else if (wr_en)
    begin
      if (hit_mode)
        grp_nonoverlap <= pwdata[3:0];
      if (hit_trig)
        trig_sel <= pwdata[7:0];
      if (hit_en_lo)
        data_enable_low <= pwdata[7:0];
      if (hit_en_hi)
        data_enable_high <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // next data writes
  // ****************************************************************
  // the slot a nibble lives in moves with the trigger pairing, but the
  // stored nibbles stay put, so next data survives a change of the selects
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      next_data <= POTC_RST_NEXT;
    else if (wr_en)
    begin
      if (hit_g3)
      begin
        next_data[15:12] <= pwdata[7:4];
        if (same_23)
          next_data[11:8] <= pwdata[3:0];
      end
      if (hit_g2 && !same_23)
        next_data[11:8] <= pwdata[3:0];
      if (hit_g1)
      begin
        next_data[7:4] <= pwdata[7:4];
        if (same_01)
          next_data[3:0] <= pwdata[3:0];
      end
      if (hit_g0 && !same_01)
        next_data[3:0] <= pwdata[3:0];
    end
  end

  // ****************************************************************
  // output groups
  // ****************************************************************
  // one vector so each group can take its own nibble of enables
  assign enable_all = {data_enable_high, data_enable_low};

  // match pulses are used as-is; a held level would retrigger
  for (genvar g = 0; g < POTC_GROUPS; g++)
  begin : g_grp
    potc_group u_grp (
      .pclk        (pclk),
      .presetn     (presetn),
      .cm_a        (cm_a),
      .cm_b        (cm_b),
      .trig_sel    (trig_sel[g*POTC_SEL_W +: POTC_SEL_W]),
      .nonoverlap  (grp_nonoverlap[g]),
      .next_bits   (next_data[g*POTC_GRP_W +: POTC_GRP_W]),
      .out_enable  (enable_all[g*POTC_GRP_W +: POTC_GRP_W]),
      .pattern_out (grp_out[g*POTC_GRP_W +: POTC_GRP_W])
    );
  end

  // ****************************************************************
  // pins
  // ****************************************************************
  // group flops already hold the value; these are plain renames
  always_comb
  begin
    pattern_out = grp_out;
    port_a_pin  = grp_out[7:0];
    port_a_oe   = data_enable_low;
    port_b_pin  = grp_out[15:8];
    port_b_oe   = data_enable_high;
  end

endmodule

// [potc_pkg.sv]
package potc_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] POTC_IDX_MODE    = 8'ha0; // output_mode_select
  localparam logic [7:0] POTC_IDX_TRIG    = 8'ha1; // trigger_channel_select
  localparam logic [7:0] POTC_IDX_EN_HI   = 8'ha2; // data_enable_high
  localparam logic [7:0] POTC_IDX_EN_LO   = 8'ha3; // data_enable_low
  localparam logic [7:0] POTC_IDX_NXT_G3  = 8'ha4; // next data, groups 3 (and 2 when shared)
  localparam logic [7:0] POTC_IDX_NXT_G1  = 8'ha5; // next data, groups 1 (and 0 when shared)
  localparam logic [7:0] POTC_IDX_NXT_G2  = 8'ha6; // next data, group 2 when split
  localparam logic [7:0] POTC_IDX_NXT_G0  = 8'ha7; // next data, group 0 when split
  localparam logic [7:0] POTC_IDX_STATUS  = 8'ha8; // live pattern outputs

  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int POTC_GROUPS    = 4;   // output groups
  localparam int POTC_GRP_W     = 4;   // bits per group
  localparam int POTC_CHANNELS  = 4;   // timer channels
  localparam int POTC_SEL_W     = 2;   // trigger select field width
  localparam int POTC_OUT_W     = 16;  // pattern outputs

  // ****************************************************************
  // values after reset and reserved read values
  // ****************************************************************
  localparam logic [3:0]  POTC_RST_NONOV  = 4'h0;
  localparam logic [7:0]  POTC_RST_TRIG   = 8'hff;  // every group on channel 3
  localparam logic [7:0]  POTC_RST_EN     = 8'h00;
  localparam logic [15:0] POTC_RST_NEXT   = 16'h0000;
  localparam logic [15:0] POTC_RST_OUT    = 16'h0000;
  localparam logic [3:0]  POTC_RSVD_NIB   = 4'hf;   // unused nibbles read as ones
  localparam logic [7:0]  POTC_RSVD_BYTE  = 8'hff;  // unused byte reads as ones

endpackage

// [potc_group.sv]
`timescale 1ns/1ps
// one four-bit output group: trigger pick and output update
module potc_group
  import potc_pkg::*;
(
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic [potc_pkg::POTC_CHANNELS-1:0] cm_a,
  input  wire logic [potc_pkg::POTC_CHANNELS-1:0] cm_b,
  input  wire logic [potc_pkg::POTC_SEL_W-1:0]    trig_sel,
  input  wire logic                              nonoverlap,
  input  wire logic [potc_pkg::POTC_GRP_W-1:0]    next_bits,
  input  wire logic [potc_pkg::POTC_GRP_W-1:0]    out_enable,
  output logic      [potc_pkg::POTC_GRP_W-1:0]    pattern_out
);

  // ****************************************************************
  // trigger selection
  // ****************************************************************
  wire logic                    hit_a;     // selected channel, match a
  wire logic                    hit_b;     // selected channel, match b
  wire logic [POTC_GRP_W-1:0]   rise_set;  // bits going high at match a
  wire logic [POTC_GRP_W-1:0]   fall_clr;  // bits going low at match b
  wire logic [POTC_GRP_W-1:0]   next_out;  // value for the next edge

  assign hit_a = cm_a[trig_sel];
  assign hit_b = cm_b[trig_sel];

  // non-overlap: ones only on a, zeros only on b, so a falling bit
  // and a rising bit stand high together only when match a comes before match b
  assign rise_set = out_enable & next_bits & {POTC_GRP_W{hit_a}};
  assign fall_clr = out_enable & ~next_bits & {POTC_GRP_W{hit_b}};

  // normal mode copies every enabled bit on match a only
  assign next_out = nonoverlap
                  ? ((pattern_out | rise_set) & ~fall_clr)
                  : (hit_a ? ((pattern_out & ~out_enable)
                              | (next_bits & out_enable))
                           : pattern_out);

  // ****************************************************************
  // output register
  // ****************************************************************
  // disabled bits hold their last value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pattern_out <= POTC_RST_OUT[POTC_GRP_W-1:0];
    else
      pattern_out <= next_out;
  end

endmodule

// [potc_monitor.sv]
`timescale 1ns/1ps
// ****************************************
// port checker for the pattern output unit
// ****************************************
module potc_monitor
  import potc_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [3:0]        cm_a,
  input wire logic [3:0]        cm_b,
  input wire logic [15:0]       pattern_out,
  input wire logic [7:0]        port_a_pin,
  input wire logic [7:0]        port_a_oe,
  input wire logic [7:0]        port_b_pin,
  input wire logic [7:0]        port_b_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access edges of writes to the two enable registers
  sequence s_wr_lo;
    psel && penable && pwrite && paddr == ADDR_W'({POTC_IDX_EN_LO, 2'b00});
  endsequence
  sequence s_wr_hi;
    psel && penable && pwrite && paddr == ADDR_W'({POTC_IDX_EN_HI, 2'b00});
  endsequence
  property p_oe_lo; s_wr_lo |=> port_a_oe == $past(pwdata[7:0]); endproperty
  property p_oe_hi; s_wr_hi |=> port_b_oe == $past(pwdata[7:0]); endproperty
  property p_oe_cause; !$stable({port_a_oe, port_b_oe}) |-> $past(psel && penable && pwrite);
  endproperty
  property p_pin_a; port_a_pin == pattern_out[7:0]; endproperty
  property p_pin_b; port_b_pin == pattern_out[15:8]; endproperty
  // a disabled bit never moves, whatever the timer does
  property p_hold_a; ((port_a_pin ^ $past(port_a_pin)) & ~$past(port_a_oe)) == 8'h00;
  endproperty
  property p_hold_b; ((port_b_pin ^ $past(port_b_pin)) & ~$past(port_b_oe)) == 8'h00;
  endproperty
  property p_cause; !$stable(pattern_out) |-> $past(|{cm_a, cm_b}); endproperty
  property p_zero_wait; psel && penable |-> pready; endproperty
  a_oe_lo: assert property (p_oe_lo) else $error("low enable not loaded");
  a_oe_hi: assert property (p_oe_hi) else $error("high enable not loaded");
  a_oe_cause: assert property (p_oe_cause) else $error("enable moved unbidden");
  a_pin_a: assert property (p_pin_a) else $error("port a differs from outputs");
  a_pin_b: assert property (p_pin_b) else $error("port b differs from outputs");
  a_hold_a: assert property (p_hold_a) else $error("disabled low bit changed");
  a_hold_b: assert property (p_hold_b) else $error("disabled high bit changed");
  a_cause: assert property (p_cause) else $error("outputs moved with no match");
  a_zero_wait: assert property (p_zero_wait) else $error("access not answered");
endmodule

bind potc_top potc_monitor #(.ADDR_W(ADDR_W)) potc_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cm_a(cm_a), .cm_b(cm_b), .pattern_out(pattern_out), .port_a_pin(port_a_pin),
  .port_a_oe(port_a_oe), .port_b_pin(port_b_pin), .port_b_oe(port_b_oe)
);

// [potc_timer_model.sv]
`timescale 1ns/1ps
// ****************************************
// timer channel compare match source
// ****************************************
module potc_timer_model
(
  input wire logic pclk,
  output logic [3:0] cm_a,
  output logic [3:0] cm_b
);
  initial cm_a = 4'h0;
  initial cm_b = 4'h0;
  // one-cycle match pulse after an optional delay
  task fire(input logic use_b, input logic [1:0] ch, input int dly);
    repeat (dly) @(posedge pclk);
    if (use_b)
      cm_b[ch] <= 1'b1;
    else
      cm_a[ch] <= 1'b1;
    @(posedge pclk);
    cm_a <= 4'h0;
    cm_b <= 4'h0;
    @(posedge pclk);
  endtask
endmodule

// [potc_top_test.sv]
`timescale 1ns/1ps
module potc_top_test;
  import potc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic [3:0] cm_a, cm_b;
  logic [15:0] pattern_out;
  logic [7:0] port_a_pin, port_a_oe, port_b_pin, port_b_oe;
  int miscompares = 0;
  int check_count = 0;
  always #12.5 pclk = ~pclk;
  potc_top potc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cm_a(cm_a), .cm_b(cm_b), .pattern_out(pattern_out),
    .port_a_pin(port_a_pin), .port_a_oe(port_a_oe), .port_b_pin(port_b_pin),
    .port_b_oe(port_b_oe));
  potc_timer_model potc_timer_model_inst (.pclk(pclk), .cm_a(cm_a), .cm_b(cm_b));
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // apb transfer, waits for pready, then an idle edge
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, {24'h0, d}, r, e);
  endtask
  task rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(nm, exp, r);
  endtask
  task out_chk(input logic [15:0] exp);
    chk("pattern_out", {16'h0, exp}, {16'h0, pattern_out});
    chk("port pins", {16'h0, exp}, {16'h0, port_b_pin, port_a_pin});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    logic [31:0] r;
    logic e;
    rd_chk("mode", POTC_IDX_MODE, 32'hf0);
    rd_chk("trig", POTC_IDX_TRIG, 32'hff);
    rd_chk("en_hi", POTC_IDX_EN_HI, 32'h0);
    rd_chk("en_lo", POTC_IDX_EN_LO, 32'h0);
    out_chk(16'h0000);
    chk("oe reset", 32'h0, {16'h0, port_b_oe, port_a_oe});
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
  endtask
  // each group on its own channel, fired one by one
  task t_split;
    logic [15:0] exp;
    exp = 16'h0;
    wr(POTC_IDX_EN_LO, 8'hff);
    wr(POTC_IDX_EN_HI, 8'hff);
    wr(POTC_IDX_TRIG, 8'he4);
    wr(POTC_IDX_NXT_G3, 8'hc0);
    wr(POTC_IDX_NXT_G2, 8'h09);
    wr(POTC_IDX_NXT_G1, 8'h60);
    wr(POTC_IDX_NXT_G0, 8'h03);
    potc_timer_model_inst.fire(1'b1, 2'd0, 0);
    out_chk(exp);
    for (int c = 0; c < 4; c++)
    begin
      potc_timer_model_inst.fire(1'b0, c[1:0], c);
      exp[4*c +: 4] = 4'(16'hc963 >> (4*c));
      out_chk(exp);
    end
  endtask
  task t_shared;
    wr(POTC_IDX_TRIG, 8'h00);
    wr(POTC_IDX_NXT_G3, 8'h5a);
    wr(POTC_IDX_NXT_G1, 8'h3c);
    rd_chk("idle byte", POTC_IDX_NXT_G2, 32'hff);
    potc_timer_model_inst.fire(1'b0, 2'd0, 2);
    out_chk(16'h5a3c);
  endtask
  // half the bits enabled: the rest must hold
  task t_enable;
    wr(POTC_IDX_EN_LO, 8'h0f);
    wr(POTC_IDX_EN_HI, 8'hf0);
    chk("oe", 32'hf00f, {16'h0, port_b_oe, port_a_oe});
    wr(POTC_IDX_NXT_G3, 8'hff);
    wr(POTC_IDX_NXT_G1, 8'hff);
    potc_timer_model_inst.fire(1'b0, 2'd0, 0);
    out_chk(16'hfa3f);
  endtask
  task t_nonov;
    wr(POTC_IDX_EN_LO, 8'hff);
    wr(POTC_IDX_EN_HI, 8'hff);
    wr(POTC_IDX_MODE, 8'h0f);
    rd_chk("mode", POTC_IDX_MODE, 32'hff);
    wr(POTC_IDX_NXT_G3, 8'h0f);
    wr(POTC_IDX_NXT_G1, 8'hf0);
    potc_timer_model_inst.fire(1'b1, 2'd0, 0);
    out_chk(16'h0a30);
    potc_timer_model_inst.fire(1'b0, 2'd0, 1);
    out_chk(16'h0ff0);
    rd_chk("status", POTC_IDX_STATUS, 32'h0ff0);
  endtask
  task end_of_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_split;
    t_shared;
    t_enable;
    t_nonov;
    end_of_test;
  end
  // watchdog: the run needs far fewer than 40000 cycles
  initial
  begin
    #1000000;
    miscompares++;
    end_of_test;
  end
endmodule
